// file: core/tpu_top.sv
// two-pin serial port: register slave, transmitter, receiver and interrupt identification
// Contract
// R1 - eight-bit scratch register, read/write, no effect on anything
// R2 - bit rate is 40 MHz divided by sixteen times the divisor
// R3 - divisor is one 16-bit field, single access, resets to one
// R4 - software keeps the divisor at four or more
// R5 - low and high byte aliases of the divisor, reset one and zero
// R6 - received character moves to the receive register; unread previous sets overrun
// R7 - transmit write fills holding register; idle shifter takes it and starts sending
// R8 - enable bit 2 gates the line status interrupt
// R9 - enable bit 1 gates the transmit holding empty interrupt
// R10 - enable bit 0 gates data ready and character time-out interrupts
// R11 - identification bits 7:6 read 11 with buffers enabled, else 00
// R12 - identifier codes: 3 line status, 2 data, 1 transmit empty, 0 modem
// R13 - only the highest priority active source is reported
// R14 - reading line status clears its interrupt; modem status read clears modem
// R15 - data interrupt clears only once the receive buffer is empty
// R16 - transmit empty interrupt clears on a transmit data write
// R17 - identification bit 0 is low while any unmasked interrupt is active
// R18 - receive trigger 1, 4, 8, 14; data interrupt when depth equals it
// R19 - transmit trigger 1, 4, 8, 12; empty interrupt at or below it
// R20 - buffer control bit 3 is plain storage
// R21 - bit 2 flushes transmit buffer, bit 1 receive buffer; shifters untouched
// R22 - bit 0 enables 16-deep buffers, else one deep; change flushes both
// R23 - word length 5 to 8 bits; stop 1, or 1.5 / 2
// R24 - parity even or odd when enabled; stick parity forces 0 or 1
// R25 - frame: low start, data lsb first, parity, high stop, idle high
module tpu_top (
  input wire logic clk,
  input wire logic rst,
  input wire tpu_pkg::tpu_addr_t busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [31:0] busRdata,
  input wire logic rxd,
  output logic txd,
  output logic irqPending
);
  import tpu_pkg::*;

  logic [7:0] scratch_r;
  logic [7:0] lcr_r;
  logic [IE_W-1:0] ier_r;
  logic [15:0] div_r;
  logic fifoEn_r;
  logic unusedXfer_r;
  logic [1:0] rxThrSel_r;
  logic [1:0] txThrSel_r;
  logic oe_r;
  logic pe_r;
  logic fe_r;
  logic bi_r;
  logic rxIrq_r;
  logic thrIrq_r;
  logic txLow_r;
  logic [9:0] toCnt_r;
  logic [31:0] rdata_r;
  logic rxSel_r;
  logic irq_r;
  logic tick;
  logic wrTx;
  logic wrFcr;
  logic rdRx;
  logic rdLsr;
  logic enChange;
  logic rxFlush;
  logic txFlush;
  logic [CNT_W-1:0] rxThr;
  logic [CNT_W-1:0] txThr;
  logic txLow;
  logic toIrq;
  logic lsAct;
  logic rxAct;
  logic thAct;
  logic irqAny;
  logic [2:0] irqId;
  logic [2:0] lastBit;
  logic [7:0] dataMask;
  logic [5:0] stopLast;
  tpu_tx_state_t txState_r;

  tpu_fifo_if rxIf();
  tpu_fifo_if txIf();

  tpu_fifo u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .f(rxIf.mem)
  );

  tpu_fifo u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .f(txIf.mem)
  );

  tpu_baud u_baud (
    .clk(clk),
    .rst(rst),
    .divisor(div_r),
    .tick(tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register decode and configuration

  assign wrTx = busWr && (busAddr == OFF_TRANSMIT_DATA);
  assign wrFcr = busWr && (busAddr == OFF_FIFO_CONTROL);
  assign rdRx = busRd && (busAddr == OFF_RECEIVE_DATA);
  assign rdLsr = busRd && (busAddr == OFF_LINE_STATUS);
  assign enChange = wrFcr && (busWdata[FCR_EN] != fifoEn_r);
  assign rxFlush = wrFcr && (busWdata[FCR_RXFLUSH] || enChange); // [R21] [R22]
  assign txFlush = wrFcr && (busWdata[FCR_TXFLUSH] || enChange); // [R21] [R22]

  always_ff @(posedge clk) begin
    if (rst) begin
      scratch_r <= '0;
      lcr_r <= '0;
      ier_r <= '0;
      div_r <= DIVISOR_RESET;
      fifoEn_r <= 1'b0;
      unusedXfer_r <= 1'b0;
      rxThrSel_r <= '0;
      txThrSel_r <= '0;
    end else if (busWr) begin
      case (busAddr)
        OFF_INTERRUPT_ENABLE: ier_r <= busWdata[IE_W-1:0];
        OFF_FIFO_CONTROL: begin
          fifoEn_r <= busWdata[FCR_EN]; // [R22]
          unusedXfer_r <= busWdata[FCR_UNUSED]; // [R20]
          txThrSel_r <= busWdata[FCR_TXTHR +: 2];
          rxThrSel_r <= busWdata[FCR_RXTHR +: 2];
        end
        OFF_LINE_CONTROL: lcr_r <= busWdata[7:0];
        OFF_SCRATCH_STORAGE: scratch_r <= busWdata[7:0]; // [R1]
        OFF_BAUD_DIVISOR: div_r <= busWdata[15:0]; // [R3]
        OFF_BAUD_DIVISOR_LOW: div_r[7:0] <= busWdata[7:0]; // [R5]
        OFF_BAUD_DIVISOR_HIGH: div_r[15:8] <= busWdata[7:0]; // [R5]
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path: receive data comes straight from the buffer's read register

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= '0;
      rxSel_r <= 1'b0;
    end else begin
      rxSel_r <= rdRx;
      rdata_r <= '0;
      if (busRd) begin
        case (busAddr)
          OFF_INTERRUPT_ENABLE: rdata_r <= 32'(ier_r);
          OFF_INTERRUPT_ID: rdata_r <= 32'({{2{fifoEn_r}}, 2'b00, irqId, ~irqAny}); // [R11] [R17]
          OFF_FIFO_CONTROL: rdata_r <= 32'({rxThrSel_r, txThrSel_r, unusedXfer_r, 2'b00, fifoEn_r});
          OFF_LINE_CONTROL: rdata_r <= 32'(lcr_r);
          OFF_LINE_STATUS: rdata_r <= 32'({pe_r || fe_r || bi_r, txIf.empty && txState_r == TX_IDLE,
                                           txIf.empty, bi_r, fe_r, pe_r, oe_r, !rxIf.empty});
          OFF_SCRATCH_STORAGE: rdata_r <= 32'(scratch_r);
          OFF_BAUD_DIVISOR: rdata_r <= 32'(div_r); // [R3]
          OFF_BAUD_DIVISOR_LOW: rdata_r <= 32'(div_r[7:0]); // [R5]
          OFF_BAUD_DIVISOR_HIGH: rdata_r <= 32'(div_r[15:8]); // [R5]
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  assign busRdata = rxSel_r ? 32'(rxIf.rdata) : rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // character format

  assign lastBit = 3'(lcr_r[LCR_WLS +: 2]) + LAST_BIT_MIN; // [R23]
  assign dataMask = 8'hff >> (3'h7 - lastBit);
  assign stopLast = !lcr_r[LCR_STB] ? BIT_LAST : // [R23]
                    (lcr_r[LCR_WLS +: 2] == 2'b00) ? STOP15_LAST : STOP2_LAST;

  function automatic logic parityOf(input logic [7:0] d, input logic [7:0] m, input logic even,
                                    input logic stick);
    logic ones;
    ones = ^(d & m);
    parityOf = stick ? !even : (even ? ones : !ones); // [R24]
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // transmitter

  logic [7:0] txSh_r;
  logic [2:0] txBit_r;
  logic [5:0] txTick_r;
  logic txPar_r;
  logic txOut_r;
  logic txLine;
  logic txBitEnd;

  assign txIf.push = wrTx; // [R7]
  assign txIf.wdata = busWdata[7:0];
  assign txIf.flush = txFlush;
  assign txIf.limit = fifoEn_r ? FULL_DEPTH : ONE_CHAR; // [R22]
  assign txIf.pop = (txState_r == TX_IDLE) && !txIf.empty; // [R7]
  assign txBitEnd = tick && (txTick_r == BIT_LAST);

  // shifter is not touched by a flush; only the buffer empties
  always_ff @(posedge clk) begin
    if (rst) begin
      txState_r <= TX_IDLE;
      txSh_r <= '0;
      txBit_r <= '0;
      txTick_r <= '0;
      txPar_r <= 1'b0;
    end else begin
      if (tick) begin
        txTick_r <= txTick_r + 6'h01;
      end
      case (txState_r)
        TX_IDLE: begin
          if (!txIf.empty) begin
            txState_r <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          txSh_r <= txIf.rdata;
          txPar_r <= parityOf(txIf.rdata, dataMask, lcr_r[LCR_EPS], lcr_r[LCR_STICK]); // [R24]
          txTick_r <= '0;
          txState_r <= TX_START;
        end
        TX_START: begin
          if (txBitEnd) begin
            txTick_r <= '0;
            txBit_r <= '0;
            txState_r <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (txBitEnd) begin
            txTick_r <= '0;
            txSh_r <= txSh_r >> 1; // [R25]
            txBit_r <= txBit_r + 3'h1;
            if (txBit_r == lastBit) begin
              txState_r <= lcr_r[LCR_PEN] ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (txBitEnd) begin
            txTick_r <= '0;
            txState_r <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tick && txTick_r == stopLast) begin
            txTick_r <= '0;
            txState_r <= TX_IDLE;
          end
        end
        default: txState_r <= TX_IDLE;
      endcase
    end
  end

  always_comb begin
    case (txState_r)
      TX_START: txLine = 1'b0; // [R25]
      TX_DATA: txLine = txSh_r[0];
      TX_PAR: txLine = txPar_r;
      default: txLine = 1'b1;
    endcase
  end

  // break control holds the pin low without stopping the shifter
  always_ff @(posedge clk) begin
    if (rst) begin
      txOut_r <= 1'b1;
    end else begin
      txOut_r <= txLine && !lcr_r[LCR_BRK];
    end
  end

  assign txd = txOut_r;

  //////////////////////////////////////////////////////////////////////////////
  // receiver

  tpu_rx_state_t rxState_r;
  logic rxMeta_r;
  logic rxIn_r;
  logic [7:0] rxSh_r;
  logic [2:0] rxBit_r;
  logic [5:0] rxTick_r;
  logic rxPar_r;
  logic rxDone;
  logic [7:0] rxData;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxIn_r <= 1'b1;
    end else begin
      rxMeta_r <= rxd;
      rxIn_r <= rxMeta_r;
    end
  end

  assign rxDone = (rxState_r == RX_STOP) && tick && (rxTick_r == BIT_LAST);
  assign rxData = rxSh_r >> (3'h7 - lastBit);
  assign rxIf.push = rxDone; // [R6]
  assign rxIf.wdata = rxData;
  assign rxIf.pop = rdRx;
  assign rxIf.flush = rxFlush;
  assign rxIf.limit = fifoEn_r ? FULL_DEPTH : ONE_CHAR; // [R22]

  // sampling counts start from mid start bit, so each later sample is mid-bit
  always_ff @(posedge clk) begin
    if (rst) begin
      rxState_r <= RX_IDLE;
      rxSh_r <= '0;
      rxBit_r <= '0;
      rxTick_r <= '0;
      rxPar_r <= 1'b0;
    end else begin
      if (tick) begin
        rxTick_r <= rxTick_r + 6'h01;
      end
      case (rxState_r)
        RX_IDLE: begin
          rxTick_r <= '0;
          if (!rxIn_r) begin
            rxState_r <= RX_START;
          end
        end
        RX_START: begin
          if (tick && rxTick_r == HALF_LAST) begin
            rxTick_r <= '0;
            rxBit_r <= '0;
            rxState_r <= rxIn_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (tick && rxTick_r == BIT_LAST) begin
            rxTick_r <= '0;
            rxSh_r <= {rxIn_r, rxSh_r[7:1]};
            rxBit_r <= rxBit_r + 3'h1;
            if (rxBit_r == lastBit) begin
              rxState_r <= lcr_r[LCR_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (tick && rxTick_r == BIT_LAST) begin
            rxTick_r <= '0;
            rxPar_r <= rxIn_r;
            rxState_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxDone) begin
            rxState_r <= RX_IDLE;
          end
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // line status flags: a new error wins over a status read or a flush

  logic setOe;
  logic setPe;
  logic setFe;
  logic setBi;
  logic lsClr;

  assign setOe = rxDone && rxIf.full; // [R6]
  assign setPe = rxDone && lcr_r[LCR_PEN] &&
                 (rxPar_r != parityOf(rxData, dataMask, lcr_r[LCR_EPS], lcr_r[LCR_STICK])); // [R24]
  assign setFe = rxDone && !rxIn_r;
  assign setBi = setFe && (rxData == '0) && !(lcr_r[LCR_PEN] && rxPar_r);
  assign lsClr = rdLsr || rxFlush; // [R14] [R21]

  always_ff @(posedge clk) begin
    if (rst) begin
      oe_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      bi_r <= 1'b0;
    end else begin
      oe_r <= (oe_r && !lsClr) || setOe;
      pe_r <= (pe_r && !lsClr) || setPe;
      fe_r <= (fe_r && !lsClr) || setFe;
      bi_r <= (bi_r && !lsClr) || setBi;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt sources and identification

  assign rxThr = fifoEn_r ? RX_THR[rxThrSel_r] : ONE_CHAR; // [R18]
  assign txThr = fifoEn_r ? TX_THR[txThrSel_r] : '0; // [R19]
  assign txLow = txIf.count <= txThr; // [R19]
  assign toIrq = toCnt_r == TIMEOUT_TICKS;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxIrq_r <= 1'b0;
      thrIrq_r <= 1'b1;
      txLow_r <= 1'b1;
      toCnt_r <= '0;
      irq_r <= 1'b0;
    end else begin
      rxIrq_r <= (rxIf.count == rxThr) || (rxIrq_r && !rxIf.empty); // [R15] [R18]
      txLow_r <= txLow;
      thrIrq_r <= (txLow && !txLow_r) || (thrIrq_r && !wrTx); // [R16]
      irq_r <= irqAny;
      // time-out measures silence while any character waits in the receive buffer, at any depth
      if (rxIf.empty || rxIf.push || rxIf.pop) begin
        toCnt_r <= '0;
      end else if (tick && !toIrq) begin
        toCnt_r <= toCnt_r + 10'h001;
      end
    end
  end

  assign lsAct = ier_r[IE_LINE] && (oe_r || pe_r || fe_r || bi_r); // [R8]
  assign thAct = ier_r[IE_TX_HOLDING_EMPTY_FLAG] && thrIrq_r; // [R9]
  assign rxAct = ier_r[IE_RXDATA] && (rxIrq_r || toIrq); // [R10]
  assign irqAny = lsAct || rxAct || thAct;
  assign irqId = lsAct ? ID_LINE : rxAct ? ID_RXDATA : thAct ? ID_TX_HOLDING_EMPTY_FLAG : ID_MODEM; // [R12] [R13]
  assign irqPending = irq_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_iir_fifo_bits: assert property ((busRd && busAddr == OFF_INTERRUPT_ID) |=> // [R11]
    busRdata[IIR_EN_LO +: 2] == {2{$past(fifoEn_r)}})
    else $error("identification enable bits wrong");
  a_pend_flag: assert property ((busRd && busAddr == OFF_INTERRUPT_ID) |=> // [R17]
    busRdata[IIR_PEND] == !$past(irqAny))
    else $error("pending flag wrong");
  a_line_first: assert property (lsAct |-> irqId == ID_LINE) // [R12]
    else $error("line status not reported first");
  a_rx_second: assert property ((!lsAct && rxAct) |-> irqId == ID_RXDATA) // [R13]
    else $error("data interrupt priority wrong");
  a_lsr_clear: assert property ((rdLsr && !rxDone) |=> !(oe_r || pe_r || fe_r || bi_r)) // [R14]
    else $error("status read did not clear errors");
  a_rxirq_hold: assert property ((rxIrq_r && !rxIf.empty && !rxFlush) |=> rxIrq_r) // [R15]
    else $error("data interrupt dropped early");
  a_tx_holding_empty_flag_clear: assert property ((wrTx && !(txLow && !txLow_r)) |=> !thrIrq_r) // [R16]
    else $error("transmit write did not clear empty interrupt");
  a_div_low: assert property ((busWr && busAddr == OFF_BAUD_DIVISOR_LOW) |=> // [R5]
    div_r[7:0] == $past(busWdata[7:0]))
    else $error("divisor low alias not written");
  a_overrun_set: assert property ((rxDone && rxIf.full) |=> oe_r) // [R6]
    else $error("overrun not flagged");
  a_start_low: assert property ((txState_r == TX_LOAD) |=> txState_r == TX_START ##1 !txd) // [R25]
    else $error("start bit not low");
  a_idle_high: assert property ((txState_r == TX_IDLE && !lcr_r[LCR_BRK]) |=> txd) // [R25]
    else $error("idle line not high");
  a_flush_both: assert property (enChange |=> rxIf.empty && txIf.empty) // [R22]
    else $error("enable change did not flush");

  c_parity_sent: cover property (txState_r == TX_PAR ##1 txState_r == TX_STOP);
  c_overrun: cover property (rxDone && rxIf.full);
  c_two_sources: cover property (lsAct && rxAct);
  c_timeout: cover property (toIrq && ier_r[IE_RXDATA]);
endmodule

// file: core/tpu_pkg.sv
// shared constants, register map and state types of the two-pin serial port
package tpu_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SRC_MHZ = 40;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned CHAR_BITS = 10;
  localparam int unsigned TIMEOUT_CHARS = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned ACC_W = 24;

  typedef logic [7:0] tpu_addr_t;
  localparam tpu_addr_t OFF_RECEIVE_DATA = 8'h00;
  localparam tpu_addr_t OFF_TRANSMIT_DATA = 8'h04;
  localparam tpu_addr_t OFF_INTERRUPT_ENABLE = 8'h08;
  localparam tpu_addr_t OFF_INTERRUPT_ID = 8'h0c;
  localparam tpu_addr_t OFF_FIFO_CONTROL = 8'h10;
  localparam tpu_addr_t OFF_LINE_CONTROL = 8'h14;
  localparam tpu_addr_t OFF_LINE_STATUS = 8'h1c;
  localparam tpu_addr_t OFF_MODEM_STATUS = 8'h20;
  localparam tpu_addr_t OFF_SCRATCH_STORAGE = 8'h24;
  localparam tpu_addr_t OFF_BAUD_DIVISOR = 8'h28;
  localparam tpu_addr_t OFF_BAUD_DIVISOR_LOW = 8'h2c;
  localparam tpu_addr_t OFF_BAUD_DIVISOR_HIGH = 8'h30;

  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam int unsigned IE_W = 3;
  localparam int unsigned IE_RXDATA = 0;
  localparam int unsigned IE_TX_HOLDING_EMPTY_FLAG = 1;
  localparam int unsigned IE_LINE = 2;
  localparam int unsigned IIR_PEND = 0;
  localparam int unsigned IIR_EN_LO = 6;
  localparam int unsigned FCR_EN = 0;
  localparam int unsigned FCR_RXFLUSH = 1;
  localparam int unsigned FCR_TXFLUSH = 2;
  localparam int unsigned FCR_UNUSED = 3;
  localparam int unsigned FCR_TXTHR = 4;
  localparam int unsigned FCR_RXTHR = 6;
  localparam int unsigned LCR_WLS = 0;
  localparam int unsigned LCR_STB = 2;
  localparam int unsigned LCR_PEN = 3;
  localparam int unsigned LCR_EPS = 4;
  localparam int unsigned LCR_STICK = 5;
  localparam int unsigned LCR_BRK = 6;

  localparam logic [2:0] ID_LINE = 3'h3;
  localparam logic [2:0] ID_RXDATA = 3'h2;
  localparam logic [2:0] ID_TX_HOLDING_EMPTY_FLAG = 3'h1;
  localparam logic [2:0] ID_MODEM = 3'h0;
  localparam logic [2:0] LAST_BIT_MIN = 3'h4;
  localparam logic [CNT_W-1:0] RX_THR [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  localparam logic [CNT_W-1:0] TX_THR [4] = '{5'h01, 5'h04, 5'h08, 5'h0c};
  localparam logic [CNT_W-1:0] ONE_CHAR = 5'h01;
  localparam logic [CNT_W-1:0] FULL_DEPTH = CNT_W'(FIFO_DEPTH);

  localparam logic [5:0] BIT_LAST = 6'(OVERSAMPLE - 1);
  localparam logic [5:0] HALF_LAST = 6'(OVERSAMPLE / 2 - 1);
  localparam logic [5:0] STOP15_LAST = 6'(OVERSAMPLE * 3 / 2 - 1);
  localparam logic [5:0] STOP2_LAST = 6'(OVERSAMPLE * 2 - 1);
  localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_CHARS * CHAR_BITS * OVERSAMPLE);

  typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PAR, TX_STOP} tpu_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} tpu_rx_state_t;
endpackage

// file: core/tpu_fifo_if.sv
// request and status bundle between the port logic and one character buffer
interface tpu_fifo_if;
  import tpu_pkg::*;
  logic push;
  logic pop;
  logic flush;
  logic [CNT_W-1:0] limit;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [CNT_W-1:0] count;
  logic full;
  logic empty;
  modport user (output push, pop, flush, limit, wdata, input rdata, count, full, empty);
  modport mem (input push, pop, flush, limit, wdata, output rdata, count, full, empty);
endinterface

// file: core/tpu_fifo.sv
// sixteen-entry character buffer with a settable depth limit and registered read data
module tpu_fifo (
  input wire logic clk,
  input wire logic rst,
  tpu_fifo_if.mem f
);
  import tpu_pkg::*;
  logic [7:0] mem_r [FIFO_DEPTH];
  logic [PTR_W-1:0] wptr_r;
  logic [PTR_W-1:0] rptr_r;
  logic [CNT_W-1:0] count_r;
  logic [7:0] rdata_r;
  logic doPush;
  logic doPop;

  // the limit makes the same storage act as a one-character holding register
  assign f.full = count_r >= f.limit;
  assign f.empty = count_r == '0;
  assign f.count = count_r;
  assign f.rdata = rdata_r;
  assign doPush = f.push && !f.full && !f.flush;
  assign doPop = f.pop && !f.empty && !f.flush;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_r[wptr_r] <= f.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || f.flush) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        wptr_r <= wptr_r + PTR_W'(1);
      end
      if (doPop) begin
        rptr_r <= rptr_r + PTR_W'(1);
      end
      count_r <= count_r + CNT_W'(doPush) - CNT_W'(doPop);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (doPop) begin
      rdata_r <= mem_r[rptr_r];
    end
  end

  a_count_bound: assert property (@(posedge clk) disable iff (rst) count_r <= FULL_DEPTH) // [R22]
    else $error("buffer count above depth");
  a_one_deep: assert property (@(posedge clk) disable iff (rst) (f.limit == ONE_CHAR && !f.empty) |-> f.full) // [R22]
    else $error("one-deep buffer accepts a second character");
endmodule

// file: core/tpu_baud.sv
// oversampling tick generator: 16x bit rate from a 40 MHz source rate over the divisor
module tpu_baud (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] divisor,
  output logic tick
);
  import tpu_pkg::*;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] lim;
  logic [ACC_W-1:0] sum;
  logic tick_r;

  // fractional accumulator keeps the 40 MHz ratio exact on the faster system clock
  assign lim = ACC_W'(CLK_MHZ) * ACC_W'(divisor);
  assign sum = acc_r + ACC_W'(SRC_MHZ);
  assign tick = tick_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= '0;
      tick_r <= 1'b0;
    end else if (sum >= lim) begin // [R2]
      // a divisor made smaller mid-count restarts instead of firing a burst of ticks
      acc_r <= (sum - lim >= lim) ? '0 : sum - lim;
      tick_r <= 1'b1;
    end else begin
      acc_r <= sum;
      tick_r <= 1'b0;
    end
  end

  a_tick_gap: assert property (@(posedge clk) disable iff (rst || divisor == '0) tick_r |=> !tick_r) // [R2]
    else $error("oversample ticks too close");
endmodule

// file: tb/tpu_remote.sv
// far-side serial device model: eight data bits, one stop bit, 400 clocks per bit
module tpu_remote (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // divisor 4: 40 MHz / 64 bit rate, 400 clocks per bit at 250 MHz
  localparam int BIT_CLKS = 400;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
  // samples each bit in its middle; returns in the middle of the stop bit
  task automatic grab(output logic [7:0] b);
    @(negedge txd);
    repeat (BIT_CLKS * 3 / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd;
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
endmodule

// file: tb/two_pin_uart_with_fifos_test.sv
// self-checking bench: register map, divisor aliases, identification, both serial directions
module two_pin_uart_with_fifos_test;
  import tpu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, busWr = 1'b0, busRd = 1'b0, rxd, txd, irqPending;
  tpu_addr_t busAddr = '0;
  logic [31:0] busWdata = '0, busRdata, seed = 32'h39a2a821;
  logic [7:0] ch;
  int nMismatch = 0, checkCount = 0, cycles = 0;
  tpu_top tpu_top_i(.clk(clk), .rst(rst), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .busRdata(busRdata), .rxd(rxd), .txd(txd), .irqPending(irqPending));
  tpu_remote tpu_remote_i(.clk(clk), .txd(txd), .rxd(rxd));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input tpu_addr_t a, input logic [31:0] d);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge clk);
    busWr <= 1'b0;
    @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe: look at mid-cycle
  task automatic rd(input tpu_addr_t a, input logic [31:0] e);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clk);
    busRd <= 1'b0;
    @(negedge clk);
    check(busRdata, e);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nMismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFF_BAUD_DIVISOR, 32'h1);
    rd(OFF_BAUD_DIVISOR_LOW, 32'h1);
    rd(OFF_BAUD_DIVISOR_HIGH, 32'h0);
    rd(OFF_SCRATCH_STORAGE, 32'h0);
    rd(OFF_INTERRUPT_ID, 32'h1);
    rd(8'h3c, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(OFF_SCRATCH_STORAGE, seed);
      rd(OFF_SCRATCH_STORAGE, {24'h0, seed[7:0]});
      wr(OFF_BAUD_DIVISOR, seed | 32'h4);
      rd(OFF_BAUD_DIVISOR_HIGH, {24'h0, seed[15:8]});
      wr(OFF_BAUD_DIVISOR_LOW, 32'h5a);
      rd(OFF_BAUD_DIVISOR, {16'h0, seed[15:8], 8'h5a});
    end
    wr(OFF_BAUD_DIVISOR, 32'h4);
    wr(OFF_LINE_CONTROL, 32'h3);
    wr(OFF_FIFO_CONTROL, 32'h1);
    rd(OFF_INTERRUPT_ID, 32'hc1);
    wr(OFF_INTERRUPT_ENABLE, 32'h2);
    rd(OFF_INTERRUPT_ID, 32'hc2);
    seed = lfsr(seed);
    fork
      tpu_remote_i.grab(ch);
      wr(OFF_TRANSMIT_DATA, seed);
    join
    check({24'h0, ch}, {24'h0, seed[7:0]});
    check({31'h0, txd}, 32'h1);
    wr(OFF_INTERRUPT_ENABLE, 32'h1);
    seed = lfsr(seed);
    tpu_remote_i.send(seed[7:0]);
    rd(OFF_INTERRUPT_ID, 32'hc4);
    rd(OFF_RECEIVE_DATA, {24'h0, seed[7:0]});
    rd(OFF_INTERRUPT_ID, 32'hc1);
    // one-deep buffer: second character overruns and is dropped
    wr(OFF_FIFO_CONTROL, 32'h0);
    tpu_remote_i.send(8'ha5);
    tpu_remote_i.send(8'h3c);
    wr(OFF_INTERRUPT_ENABLE, 32'h4);
    rd(OFF_INTERRUPT_ID, 32'h06);
    check({31'h0, irqPending}, 32'h1);
    rd(OFF_LINE_STATUS, 32'h63);
    rd(OFF_INTERRUPT_ID, 32'h01);
    check({31'h0, irqPending}, 32'h0);
    rd(OFF_RECEIVE_DATA, 32'ha5);
    give_verdict();
  end
endmodule
